// [bmc_fall_sample.sv]
// falling-edge sampler of a terminate input, held for the rising edge
`timescale 1ns/1ps
module bmc_fall_sample (
  input wire logic mclk,
  input wire logic rst,
  input wire logic pinIn,
  output logic sampled
);

  logic fall_r;

  // -------------------------------------------------------------
  // sample on the falling edge, hold for the rising edge
  // -------------------------------------------------------------
  always_ff @(negedge mclk or posedge rst) begin
    if (rst) begin
      fall_r <= 1'h1;
    end else begin
      fall_r <= pinIn;
    end
  end

  assign sampled = fall_r;

endmodule

// [bmc_master.sv]
// bus master memory cycle sequencer: first, second, wait and idle states
`timescale 1ns/1ps
module bmc_master (
  input wire logic mclk,
  input wire logic rst,
  input wire logic busFamily,
  input wire logic [bmc_pkg::WAIT_W-1:0] waitStates,
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic reqDescriptor,
  input wire logic [bmc_pkg::ADDR_W-1:0] reqAddr,
  input wire logic [bmc_pkg::DATA_W-1:0] reqWdata,
  output logic reqReady,
  output logic doneValid,
  output logic [bmc_pkg::DATA_W-1:0] doneRdata,
  output logic [bmc_pkg::ADDR_W-1:0] memAddr,
  output logic addressStrobeLowActive,
  output logic addressValidStrobe,
  output logic earlyCycleStrobe,
  output logic dataStrobe,
  output logic readWriteSelectLine,
  input wire logic memoryReadyInput,
  input wire logic sizeAcknowledgePair,
  input wire logic synchronousTermination,
  input wire logic [bmc_pkg::DATA_W-1:0] memDataIn,
  output logic [bmc_pkg::DATA_W-1:0] memDataOut,
  output logic memDataOe
);

  // ---------------------------------------------------------------
  // state and registers
  // ---------------------------------------------------------------
  bmc_pkg::bmc_state_t state_r, state_nxt;
  logic [bmc_pkg::WAIT_W-1:0] waitCnt_r, waitCnt_nxt;
  logic write_r;
  logic desc_r;
  logic lastDescWrite_r, lastDescWrite_nxt;
  logic hadWait_r, hadWait_nxt;
  logic firstSecond_r, firstSecond_nxt;
  logic readySampled;
  logic ackSync;

  // ---------------------------------------------------------------
  // input sampling
  // ---------------------------------------------------------------
  // ready is caught on the falling edge so its setup spans half a clock
  bmc_fall_sample u_ready (
    .mclk(mclk),
    .rst(rst),
    .pinIn(memoryReadyInput),
    .sampled(readySampled)
  );

  // size acknowledge takes the asynchronous path
  bmc_sync u_ack (
    .mclk(mclk),
    .rst(rst),
    .asyncIn(sizeAcknowledgePair),
    .syncOut(ackSync)
  );

  // ---------------------------------------------------------------
  // decode of terminations and starts
  // ---------------------------------------------------------------
  wire readyFamily = (busFamily == bmc_pkg::FAMILY_READY);
  wire waitsDone = (waitCnt_r == bmc_pkg::WAIT_ZERO);
  wire readyLow = readySampled == 1'h0;
  // synchronous_termination taken straight on the rising edge
  wire stermLow = synchronousTermination == 1'h0;
  // synchronised ack ends the cycle at the next edge, two clocks after its sample
  wire ackLow = ackSync == 1'h0;
  // a fresh ack cannot pass the synchroniser within the first state, and
  // what it holds there may be left over from the previous cycle
  wire termFirst = readyFamily & readyLow;
  wire termSecond = readyFamily ? readyLow
                  : (ackLow | (stermLow & firstSecond_r)
                     | (stermLow & ~firstSecond_r));
  wire needIdle = lastDescWrite_r & reqValid & ~reqWrite
                  & reqDescriptor;
  wire startNow = reqValid & ~needIdle;
  wire inCycle = (state_r == bmc_pkg::ST_FIRST) |
                 (state_r == bmc_pkg::ST_SECOND) |
                 (state_r == bmc_pkg::ST_WAIT);

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    waitCnt_nxt = waitCnt_r;
    lastDescWrite_nxt = lastDescWrite_r;
    hadWait_nxt = hadWait_r;
    firstSecond_nxt = firstSecond_r;
    unique case (state_r)
      bmc_pkg::ST_IDLE, bmc_pkg::ST_RELEASE: begin
        if (needIdle) begin
          state_nxt = bmc_pkg::ST_TURN;
          lastDescWrite_nxt = 1'h0;
        end else if (startNow) begin
          state_nxt = bmc_pkg::ST_FIRST;
          waitCnt_nxt = waitStates;
          hadWait_nxt = 1'h0;
          firstSecond_nxt = 1'h1;
        end else begin
          state_nxt = bmc_pkg::ST_IDLE;
        end
      end
      bmc_pkg::ST_FIRST: begin
        if (termFirst & waitsDone) begin
          state_nxt = bmc_pkg::ST_IDLE;
          lastDescWrite_nxt = write_r & desc_r;
        end else begin
          state_nxt = bmc_pkg::ST_SECOND;
        end
      end
      bmc_pkg::ST_SECOND, bmc_pkg::ST_WAIT: begin
        firstSecond_nxt = 1'h0;
        if (~waitsDone) begin
          waitCnt_nxt = waitCnt_r - 2'h1;
          hadWait_nxt = 1'h1;
          state_nxt = bmc_pkg::ST_WAIT;
        end else if (termSecond) begin
          state_nxt = bmc_pkg::ST_IDLE;
          lastDescWrite_nxt = write_r & desc_r;
        end else begin
          hadWait_nxt = 1'h1;
          state_nxt = bmc_pkg::ST_WAIT;
        end
      end
      bmc_pkg::ST_TURN: begin
        state_nxt = bmc_pkg::ST_RELEASE;
      end
      default: begin
        state_nxt = bmc_pkg::ST_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // state registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r <= bmc_pkg::ST_IDLE;
      waitCnt_r <= bmc_pkg::WAIT_ZERO;
      lastDescWrite_r <= 1'h0;
      hadWait_r <= 1'h0;
      firstSecond_r <= 1'h0;
    end else begin
      state_r <= state_nxt;
      waitCnt_r <= waitCnt_nxt;
      lastDescWrite_r <= lastDescWrite_nxt;
      hadWait_r <= hadWait_nxt;
      firstSecond_r <= firstSecond_nxt;
    end
  end

  // ---------------------------------------------------------------
  // request capture
  // ---------------------------------------------------------------
  wire starting = (state_nxt == bmc_pkg::ST_FIRST) &
                  (state_r != bmc_pkg::ST_FIRST);
  wire ending = inCycle & (state_nxt == bmc_pkg::ST_IDLE);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      write_r <= 1'h0;
      desc_r <= 1'h0;
      memAddr <= '0;
      memDataOut <= '0;
    end else if (starting) begin
      write_r <= reqWrite;
      desc_r <= reqDescriptor;
      memAddr <= reqAddr;
      memDataOut <= reqWdata;
    end
  end

  // ---------------------------------------------------------------
  // pin drive: every output registered on the rising edge
  // ---------------------------------------------------------------
  wire stayCycle = (state_nxt == bmc_pkg::ST_SECOND) |
                   (state_nxt == bmc_pkg::ST_WAIT);
  wire nextWrite = starting ? reqWrite : write_r;
  // strobe only once a wait state has begun
  wire strobeNxt = (state_nxt == bmc_pkg::ST_WAIT) |
                   (stayCycle & hadWait_nxt);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      addressStrobeLowActive <= bmc_pkg::STROBE_OFF;
      addressValidStrobe <= bmc_pkg::STROBE_OFF;
      earlyCycleStrobe <= bmc_pkg::STROBE_OFF;
      dataStrobe <= bmc_pkg::STROBE_OFF;
      readWriteSelectLine <= bmc_pkg::DIR_READ;
      memDataOe <= 1'h0;
      reqReady <= 1'h0;
      doneValid <= 1'h0;
      doneRdata <= '0;
    end else begin
      addressStrobeLowActive <= starting ? bmc_pkg::STROBE_ON
                                : bmc_pkg::STROBE_OFF;
      earlyCycleStrobe <= starting ? bmc_pkg::STROBE_ON
                          : bmc_pkg::STROBE_OFF;
      addressValidStrobe <= (starting | stayCycle) ? bmc_pkg::STROBE_ON
                            : bmc_pkg::STROBE_OFF;
      dataStrobe <= strobeNxt ? bmc_pkg::STROBE_ON
                    : bmc_pkg::STROBE_OFF;
      // direction only moves at a new start, so runs hold level
      if (starting) begin
        readWriteSelectLine <= reqWrite ? bmc_pkg::DIR_WRITE
                               : bmc_pkg::DIR_READ;
      end
      // write data kept driven through the idle, released after it
      if (starting) begin
        memDataOe <= nextWrite;
      end else if (state_r == bmc_pkg::ST_TURN) begin
        memDataOe <= 1'h0;
      end
      reqReady <= starting;
      doneValid <= ending;
      if (ending & ~write_r) begin
        doneRdata <= memDataIn;
      end
    end
  end

endmodule

// [bmc_master_sva.sv]
// assertions on the ports of the bus master memory cycle sequencer
`timescale 1ns/1ps
module bmc_master_chk (
  input wire logic mclk,
  input wire logic rst,
  input wire logic busFamily,
  input wire logic [bmc_pkg::WAIT_W-1:0] waitStates,
  input wire logic reqDescriptor,
  input wire logic reqReady,
  input wire logic doneValid,
  input wire logic addressStrobeLowActive,
  input wire logic addressValidStrobe,
  input wire logic earlyCycleStrobe,
  input wire logic dataStrobe,
  input wire logic readWriteSelectLine,
  input wire logic memoryReadyInput,
  input wire logic sizeAcknowledgePair,
  input wire logic synchronousTermination,
  input wire logic memDataOe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // ------------------------------------------------------------
  // cycle framing and termination (strobes are active low)
  // ------------------------------------------------------------
  a_first_strobes: assert property (reqReady |->
    !addressStrobeLowActive && !earlyCycleStrobe && !addressValidStrobe
    && dataStrobe) else $error("first state strobes wrong");
  a_cycle_bound: assert property (reqReady |-> ##[1:12] doneValid)
    else $error("cycle never ended");
  a_dir_steady: assert property (!reqReady |->
    $stable(readWriteSelectLine)) else $error("direction moved");
  a_ds_waits: assert property (!dataStrobe |->
    earlyCycleStrobe && !addressValidStrobe) else $error("data strobe early");
  a_ready_end: assert property (@(negedge mclk)
    !busFamily && waitStates == bmc_pkg::WAIT_ZERO && !addressValidStrobe
    && !memoryReadyInput |-> ##1 doneValid) else $error("ready end late");
  a_ack_end: assert property (busFamily && $fell(sizeAcknowledgePair)
    && waitStates == bmc_pkg::WAIT_ZERO |-> ##[1:3] doneValid)
    else $error("size ack end late");
  a_synchronous_termination_end: assert property (busFamily &&
    $fell(synchronousTermination) && waitStates == bmc_pkg::WAIT_ZERO
    |-> ##[1:2] doneValid) else $error("synchronous_termination end late");
  a_ds_no_wait: assert property (!busFamily && reqReady
    && waitStates == bmc_pkg::WAIT_ZERO && !memoryReadyInput
    |-> ##1 (dataStrobe && doneValid)) else $error("strobe without wait");
  a_no_term_hold: assert property (busFamily &&
    $past(synchronousTermination) && $past(sizeAcknowledgePair)
    && $past(sizeAcknowledgePair, 2) && $past(sizeAcknowledgePair, 3)
    |-> !doneValid) else $error("ended without termination");
  a_idle_turn: assert property (reqReady && reqDescriptor &&
    readWriteSelectLine && !$past(readWriteSelectLine)
    |-> $past(addressValidStrobe, 2)) else $error("no idle clock");
  a_read_no_drive: assert property (reqReady && readWriteSelectLine
    |-> !memDataOe) else $error("data bus driven in read");
endmodule
bind bmc_master bmc_master_chk chk_u (.*);

// [bmc_mem_model.sv]
// system memory and its termination logic facing the sequencer
`timescale 1ns/1ps
module bmc_mem_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic busFamily,
  input wire logic useSterm,
  input wire logic [1:0] delay,
  input wire logic addressValidStrobe,
  input wire logic [bmc_pkg::ADDR_W-1:0] memAddr,
  output logic memoryReadyInput,
  output logic sizeAcknowledgePair,
  output logic synchronousTermination,
  output logic [bmc_pkg::DATA_W-1:0] memDataIn
);
  logic [1:0] cnt_r;
  logic [bmc_pkg::DATA_W-1:0] last_r;
  logic term;
  // clocks spent in the current cycle, answers after delay of them
  always_ff @(posedge mclk or posedge rst) begin
    if (rst || addressValidStrobe) cnt_r <= 2'h0;
    else if (cnt_r != 2'h3) cnt_r <= cnt_r + 2'h1;
  end
  // terminations change only after rising edges
  assign term = !addressValidStrobe && cnt_r >= delay;
  assign memoryReadyInput = !(term && !busFamily);
  assign sizeAcknowledgePair = !(term && busFamily && !useSterm);
  assign synchronousTermination = !(term && busFamily && useSterm);
  // read data while selected, otherwise the inverse of the last word
  always_ff @(posedge mclk) last_r <= memDataIn;
  assign memDataIn = !addressValidStrobe ? memAddr ^ 32'hA5A50F0F : ~last_r;
endmodule

// [bmc_pkg.sv]
// package of constants and types for the bus master memory cycle sequencer
package bmc_pkg;

  // ----------------------------------------------------------------
  // bus family and widths
  // ----------------------------------------------------------------
  localparam logic FAMILY_READY = 1'h0; // ready-terminated family
  localparam logic FAMILY_ACK = 1'h1; // size ack / synchronous_termination family
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int WAIT_W = 2;
  localparam logic [WAIT_W-1:0] WAIT_ZERO = 2'h0;

  // ----------------------------------------------------------------
  // pin levels
  // ----------------------------------------------------------------
  localparam logic DIR_READ = 1'h1; // read/write select at read
  localparam logic DIR_WRITE = 1'h0;
  localparam logic STROBE_ON = 1'h0; // active-low strobes
  localparam logic STROBE_OFF = 1'h1;

  // ----------------------------------------------------------------
  // sequencer states, gray along idle-first-second-wait
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_FIRST = 3'h1,
    ST_SECOND = 3'h3,
    ST_WAIT = 3'h2,
    ST_TURN = 3'h6,
    ST_RELEASE = 3'h7
  } bmc_state_t;

endpackage

// [bmc_sync.sv]
// two-flop synchroniser for an asynchronous input
`timescale 1ns/1ps
module bmc_sync (
  input wire logic mclk,
  input wire logic rst,
  input wire logic asyncIn,
  output logic syncOut
);

  logic meta_r;

  // -------------------------------------------------------------
  // capture then settle; first flop read only by the second
  // -------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta_r <= 1'h1;
      syncOut <= 1'h1;
    end else begin
      meta_r <= asyncIn;
      syncOut <= meta_r;
    end
  end

endmodule

// [bus_master_memory_cycle_tb_top.sv]
// self-checking bench for the bus master memory cycle sequencer
`timescale 1ns/1ps
module bus_master_memory_cycle_tb_top;
  logic mclk = 0, rst = 1, busFamily = 0, useSterm = 0;
  logic reqValid = 0, reqWrite = 0, reqDescriptor = 0;
  logic [1:0] delay = 2'h0;
  logic [bmc_pkg::WAIT_W-1:0] waitStates = 2'h0;
  logic [bmc_pkg::ADDR_W-1:0] reqAddr = 32'h0, memAddr, a;
  logic [bmc_pkg::DATA_W-1:0] reqWdata = 32'h0, doneRdata, memDataIn;
  logic [bmc_pkg::DATA_W-1:0] memDataOut;
  logic reqReady, doneValid, addressStrobeLowActive, addressValidStrobe;
  logic earlyCycleStrobe, dataStrobe, readWriteSelectLine, memDataOe;
  logic memoryReadyInput, sizeAcknowledgePair, synchronousTermination;
  logic [35:0] expQ[$];
  logic [35:0] e;
  int numErrors = 0, cmpCount = 0, lat = 0, n;
  bmc_master dut_u (.*);
  bmc_mem_model mem_u (.*);
  always #20 mclk = ~mclk;
  // verdict and end of run
  task automatic tally_and_finish;
    $display("comparisons %0d errors %0d", cmpCount, numErrors);
    if (numErrors == 0 && cmpCount > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, got);
    cmpCount++;
    if (got !== ex) begin
      numErrors++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // present one request after a falling edge, hold it until taken
  task automatic issue(input logic w, d, input logic [31:0] ad);
    reqValid = 1;
    reqWrite = w;
    reqDescriptor = d;
    reqAddr = ad;
    reqWdata = $urandom;
    expQ.push_back({w, (!busFamily && waitStates == 2'h0) ? 3'(delay + 1)
      : 3'h0, w ? reqWdata : ad ^ 32'hA5A50F0F});
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (reqReady !== 1'b1 && n < 50);
    if (n == 50) begin
      numErrors++;
      tally_and_finish();
    end
    @(negedge mclk);
  endtask
  // result watcher: takes the oldest note at each completed cycle
  always @(posedge mclk) begin
    lat = (reqReady === 1'b1) ? 0 : lat + 1;
    if (doneValid === 1'b1) begin
      if (expQ.size() == 0) chk("unexpected done", 32'h0, 32'h1);
      else begin
        e = expQ.pop_front();
        if (e[35]) chk("write data", e[31:0], memDataOut);
        else chk("read data", e[31:0], doneRdata);
        if (e[34:32] != 3'h0) chk("cycle clocks", e[34:32], lat);
      end
    end
  end
  // each setting: two writes then two reads, all back to back
  initial begin
    void'($urandom(32'h2592));
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    rst = 0;
    for (int f = 0; f < 2; f++) begin
      for (int k = 0; k < 10; k++) begin
        busFamily = f[0];
        useSterm = k[0];
        delay = k[2:1];
        waitStates = (k > 7) ? 2'($urandom) : 2'h0;
        a = $urandom & 32'hFFFFFFFC;
        issue(1'b1, k[1], a);
        issue(1'b1, k[1], a + 4);
        issue(1'b0, k[1], a);
        issue(1'b0, k[1], a + 4);
        reqValid = 0;
        n = 0;
        while (expQ.size() != 0 && n < 100) begin
          @(negedge mclk);
          n++;
        end
        if (n == 100) begin
          numErrors++;
          tally_and_finish();
        end
      end
    end
    tally_and_finish();
  end
endmodule
